// ===== prot_regs_defines.vh
/*
 constants for the write-protect and bus identity register slice.
 assumes a byte-wide register access port decoded upstream of this slice.
*/
`ifndef PROT_REGS_DEFINES_VH
`define PROT_REGS_DEFINES_VH

// ------------------------------
// register offsets
// ------------------------------
`define OFS_LOCK_MASK_A 8'hF1
`define OFS_LOCK_MASK_B 8'hF2
`define OFS_CHAN_LOCK 8'hF3
`define OFS_TARGET_ID 8'hF9
`define OFS_HOST_LEVEL 8'hFA

// ------------------------------
// reset values and fields
// ------------------------------
`define RST_LOCK_MASK 8'h00
`define RST_CHAN_LOCK 8'hC1
`define CHAN_LOCK_WMASK 8'h3F
`define LOCK_MASK_WMASK 8'h3F
`define BIT_SEQ_LOCK 0
`define BIT_MON_LOCK 1
`define UPPER_ID_DEFAULT 4'hE
`define UNMAPPED_READ 8'h00
`define RST_RDATA 8'h00

`endif

// ===== strap_sync.v
/*
 two-flop synchroniser for the address strap and level inputs.
 assumes inputs are quasi-static pins from outside the mclk domain.
*/
`timescale 1ns/1ps
module strap_sync #(
   parameter WIDTH = 4
) (
   input wire mclk,
   input wire rst,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] meta_r;

   // ------------------------------
   // first stage feeds only second
   // ------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         meta_r <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule // strap_sync

// ===== prot_regs.v
/*
 write-protect masks, channel lock mask, bus target id and host level status.
 assumes a one-cycle register write/read strobe from the serial bus engine.
*/
`timescale 1ns/1ps
`include "prot_regs_defines.vh"

//Function
// RULE_01: ordering-log writes dropped when its lock is active, else they pass.
// RULE_02: channel lock mask bits 5:0 pick channels under monitor-group lock.
// RULE_03: locked channel with monitor lock active ignores its config writes.
// RULE_04: channel lock mask resets to 0xC1; bits 7:6 read-only.
// RULE_05: target id bits 6:3 return the fused upper address bits.
// RULE_06: target id bits 2:0 return strap-decoded low address, 000b to 111b.
// RULE_07: fused upper field defaults to factory value 0xE.
// RULE_08: host level status reports 0 for 3.3V, 1 for 1.2/1.8V.
// RULE_09: a group locks only when set in both protect masks.
// RULE_10: protect masks reset 0x00, sticky ones, cleared only by reset paths.
// RULE_11: host level bit 0 is read-only, reflects interface pin domain.
// RULE_12: writes to read-only id and level registers change nothing.
module prot_regs #(
   parameter CHANNELS = 6,
   parameter [3:0] UPPER_ID = `UPPER_ID_DEFAULT
) (
   input wire mclk,
   input wire rst,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire supervisor_control_reset,
   input wire selftest_on_shutdown_exit,
   input wire [2:0] addr_strap,
   input wire host_level_pin,
   input wire seq_wr_req,
   input wire [CHANNELS-1:0] chan_wr_req,
   output reg [7:0] rdata,
   output reg rvalid,
   output reg seq_wr_allow,
   output reg [CHANNELS-1:0] chan_wr_allow,
   output reg ordering_log_lock,
   output reg [CHANNELS-1:0] channel_cfg_lock_select
);
   reg [7:0] lock_mask_a_r;
   reg [7:0] lock_mask_b_r;
   reg [7:0] chan_lock_r;
   reg [7:0] rdata_nxt;
   reg [7:0] lock_mask_a_nxt;
   reg [7:0] lock_mask_b_nxt;
   reg [7:0] chan_lock_nxt;
   reg seq_wr_allow_nxt;
   reg [CHANNELS-1:0] chan_wr_allow_nxt;
   reg ordering_log_lock_nxt;
   reg [CHANNELS-1:0] channel_cfg_lock_select_nxt;
   wire [3:0] sync_out;
   wire [2:0] strap_s;
   wire level_s;
   wire mask_clear;
   wire seq_lock;
   wire mon_lock;
   wire [CHANNELS-1:0] chan_lock_on;
   wire wr_mask_a;
   wire wr_mask_b;
   wire wr_chan;
   wire [7:0] target_id_word;
   wire [7:0] host_level_word;

   function sel;
      input [7:0] a;
      input [7:0] ofs;
      begin
         sel = (a == ofs);
      end
   endfunction

   // set-only merge: ones stick until a reset path clears them
   function [7:0] sticky_set;
      input [7:0] cur;
      input [7:0] din;
      input [7:0] wmask;
      begin
         sticky_set = cur | (din & wmask);
      end
   endfunction

   // replace writable bits, keep read-only ones
   function [7:0] merge_field;
      input [7:0] cur;
      input [7:0] din;
      input [7:0] wmask;
      begin
         merge_field = (cur & ~wmask) | (din & wmask);
      end
   endfunction

   // ------------------------------
   // pin synchronisers
   // ------------------------------
   strap_sync #(.WIDTH(4)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .din({host_level_pin, addr_strap}),
      .dout(sync_out)
   );
   assign strap_s = sync_out[2:0]; // RULE_06
   assign level_s = sync_out[3]; // RULE_11

   // ------------------------------
   // read-only sources
   // ------------------------------
   assign target_id_word = {1'b0, UPPER_ID, strap_s}; // RULE_05 RULE_07
   assign host_level_word = {7'h00, level_s}; // RULE_08 RULE_11

   // ------------------------------
   // lock decode
   // ------------------------------
   assign mask_clear = supervisor_control_reset | selftest_on_shutdown_exit; // RULE_10
   assign seq_lock = lock_mask_a_r[`BIT_SEQ_LOCK] & lock_mask_b_r[`BIT_SEQ_LOCK]; // RULE_09
   assign mon_lock = lock_mask_a_r[`BIT_MON_LOCK] & lock_mask_b_r[`BIT_MON_LOCK]; // RULE_09
   assign chan_lock_on = chan_lock_r[CHANNELS-1:0] & {CHANNELS{mon_lock}}; // RULE_02

   // ------------------------------
   // write decode
   // ------------------------------
   // id and level offsets decode to nothing, so host writes there are dropped
   assign wr_mask_a = wr_en & sel(addr, `OFS_LOCK_MASK_A); // RULE_10
   assign wr_mask_b = wr_en & sel(addr, `OFS_LOCK_MASK_B); // RULE_10
   assign wr_chan = wr_en & sel(addr, `OFS_CHAN_LOCK); // RULE_04

   // ------------------------------
   // writable registers
   // ------------------------------
   // reset-path clears win over a host write landing in the same cycle
   always @* begin
      lock_mask_a_nxt = lock_mask_a_r;
      lock_mask_b_nxt = lock_mask_b_r;
      if (mask_clear) begin
         lock_mask_a_nxt = `RST_LOCK_MASK; // RULE_10
         lock_mask_b_nxt = `RST_LOCK_MASK; // RULE_10
      end else begin
         if (wr_mask_a) begin
            lock_mask_a_nxt = sticky_set(lock_mask_a_r, wdata, `LOCK_MASK_WMASK); // RULE_10
         end
         if (wr_mask_b) begin
            lock_mask_b_nxt = sticky_set(lock_mask_b_r, wdata, `LOCK_MASK_WMASK); // RULE_10
         end
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         lock_mask_a_r <= `RST_LOCK_MASK; // RULE_10
         lock_mask_b_r <= `RST_LOCK_MASK; // RULE_10
      end else begin
         lock_mask_a_r <= lock_mask_a_nxt;
         lock_mask_b_r <= lock_mask_b_nxt;
      end
   end

   // channel mask itself stays writable; locking it is outside this slice
   always @* begin
      chan_lock_nxt = chan_lock_r;
      if (wr_chan) begin
         chan_lock_nxt = merge_field(chan_lock_r, wdata, `CHAN_LOCK_WMASK); // RULE_02
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         chan_lock_r <= `RST_CHAN_LOCK; // RULE_04
      end else begin
         chan_lock_r <= chan_lock_nxt; // RULE_04
      end
   end

   // ------------------------------
   // read mux
   // ------------------------------
   always @* begin
      rdata_nxt = `UNMAPPED_READ;
      case (addr)
         `OFS_LOCK_MASK_A: rdata_nxt = lock_mask_a_r;
         `OFS_LOCK_MASK_B: rdata_nxt = lock_mask_b_r;
         `OFS_CHAN_LOCK: rdata_nxt = chan_lock_r;
         `OFS_TARGET_ID: rdata_nxt = target_id_word; // RULE_05
         `OFS_HOST_LEVEL: rdata_nxt = host_level_word; // RULE_08
         default: rdata_nxt = `UNMAPPED_READ;
      endcase
   end

   // ------------------------------
   // grant decode
   // ------------------------------
   always @* begin
      seq_wr_allow_nxt = seq_wr_req & ~seq_lock; // RULE_01
      chan_wr_allow_nxt = chan_wr_req & ~chan_lock_on; // RULE_03
      ordering_log_lock_nxt = seq_lock; // RULE_01
      channel_cfg_lock_select_nxt = chan_lock_on; // RULE_02
   end

   // ------------------------------
   // registered outputs
   // ------------------------------
   // read data holds between reads so a slow host can fetch it late
   always @(posedge mclk) begin
      if (rst) begin
         rdata <= `RST_RDATA;
         rvalid <= 1'b0;
      end else begin
         rdata <= rd_en ? rdata_nxt : rdata; // RULE_12
         rvalid <= rd_en;
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         seq_wr_allow <= 1'b0;
         chan_wr_allow <= {CHANNELS{1'b0}};
      end else begin
         seq_wr_allow <= seq_wr_allow_nxt; // RULE_01
         chan_wr_allow <= chan_wr_allow_nxt; // RULE_03
      end
   end

   // lock levels lag the masks by one cycle, as the grants do
   always @(posedge mclk) begin
      if (rst) begin
         ordering_log_lock <= 1'b0;
         channel_cfg_lock_select <= {CHANNELS{1'b0}};
      end else begin
         ordering_log_lock <= ordering_log_lock_nxt; // RULE_01
         channel_cfg_lock_select <= channel_cfg_lock_select_nxt; // RULE_02
      end
   end
endmodule // prot_regs

// ===== prot_regs_props.sv
/* port assertions for prot_regs; bound into every prot_regs instance. */
`timescale 1ns/1ps
module prot_regs_props #(parameter CHANNELS = 6, parameter [3:0] UPPER_ID = 4'hE) (
   input wire mclk,
   input wire rst,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [7:0] rdata,
   input wire rvalid,
   input wire seq_wr_req,
   input wire seq_wr_allow,
   input wire ordering_log_lock);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_rd_valid: assert property (rd_en |=> rvalid) else $error("rvalid missing");
   a_rv_stray: assert property (!rd_en |=> !rvalid) else $error("stray rvalid");
   a_seq_drop: assert property (seq_wr_req |=> seq_wr_allow == !ordering_log_lock) else $error("seq");
   a_chan_rsvd: assert property (rd_en && addr == 8'hF3 |=> rdata[7:6] == 2'b11) else $error("mask");
   a_id_upper: assert property (rd_en && addr == 8'hF9 |=> rdata[7:3] == {1'b0, UPPER_ID}) else $error("id");
   a_level_rsvd: assert property (rd_en && addr == 8'hFA |=> rdata[7:1] == 7'h00) else $error("level");
   a_unmapped_rd: assert property (rd_en && addr == 8'h00 |=> rdata == 8'h00) else $error("unmapped");
   a_rdata_hold: assert property (!rd_en |=> $stable(rdata)) else $error("rdata moved");
   cover property (rd_en && addr == 8'hF9);
   cover property (ordering_log_lock && seq_wr_req);
   cover property (seq_wr_allow);
endmodule // prot_regs_props
bind prot_regs prot_regs_props #(.CHANNELS(CHANNELS), .UPPER_ID(UPPER_ID)) u_props (.mclk(mclk), .rst(rst),
   .rd_en(rd_en), .addr(addr), .rdata(rdata), .rvalid(rvalid), .seq_wr_req(seq_wr_req),
   .seq_wr_allow(seq_wr_allow), .ordering_log_lock(ordering_log_lock));

// ===== host_model.sv
/* host side register master; calls start just after mclk rises. */
`timescale 1ns/1ps
module host_model (
   input wire mclk,
   input wire rvalid,
   input wire [7:0] rdata,
   output reg wr_en = 1'b0,
   output reg rd_en = 1'b0,
   output reg [7:0] addr = 8'h00,
   output reg [7:0] wdata = 8'h00);
   // an idle edge first, so a strobe never toggles twice in one step
   task x(input w, input [7:0] a, input [7:0] v, output [7:0] d);
      @(posedge mclk);
      #1 {wr_en, rd_en, addr, wdata} = {w, !w, a, v};
      @(posedge mclk);
      #1 {wr_en, rd_en, addr} = {2'b00, ~a};
      d = rvalid ? rdata : ~rdata;
   endtask
endmodule // host_model

// ===== write_protect_and_bus_id_regs_tb.sv
/* prot_regs regression: rows {kind, addr, value, expect}; kind 0 read, 1 write, 2 strobes, 4 strap+read. */
`timescale 1ns/1ps
module write_protect_and_bus_id_regs_tb;
   reg mclk = 1'b0, rst = 1'b1, host_level_pin = 1'b1;
   reg [2:0] addr_strap = 3'h5;
   reg [8:0] drv = 9'h000;
   reg [7:0] d;
   reg [31:0] r;
   wire wr_en, rd_en, rvalid, seq_wr_allow, ordering_log_lock;
   wire supervisor_control_reset, selftest_on_shutdown_exit, seq_wr_req;
   wire [7:0] addr, wdata, rdata;
   wire [5:0] chan_wr_req, chan_wr_allow, channel_cfg_lock_select;
   wire [6:0] lock_lvl;
   integer mismatches = 0, n_checks = 0, cyc = 0, i;
   reg [31:0] rows [0:27] = '{32'h0F100000, 32'h0F200000, 32'h0F3000C1, 32'h1F90FF00, 32'h1FA0FE00,
      32'h0F900075, 32'h0FA00001, 32'h00000000, 32'h4F900070, 32'h4F900777, 32'h20007F7F,
      32'h1F100300, 32'h20007F7F, 32'h1F200300, 32'h20007F3E, 32'h1F300200, 32'h0F3000C2,
      32'h20007F3D, 32'h1F100000, 32'h0F100003, 32'h20010000, 32'h0F100000, 32'h20007F7F,
      32'h1F100100, 32'h1F200100, 32'h20004000, 32'h20008000, 32'h0F200000};
   assign {supervisor_control_reset, selftest_on_shutdown_exit, seq_wr_req, chan_wr_req} = drv;
   assign lock_lvl = {ordering_log_lock, channel_cfg_lock_select};
   always #50 mclk = ~mclk;
   always @(posedge mclk) if (cyc == 3000) stop_test; else cyc <= cyc + 1;
   host_model h (.mclk(mclk), .rvalid(rvalid), .rdata(rdata),
      .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
   prot_regs dut (.mclk(mclk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
      .supervisor_control_reset(supervisor_control_reset), .selftest_on_shutdown_exit(selftest_on_shutdown_exit),
      .addr_strap(addr_strap), .host_level_pin(host_level_pin), .seq_wr_req(seq_wr_req), .chan_wr_req(chan_wr_req),
      .rdata(rdata), .rvalid(rvalid), .seq_wr_allow(seq_wr_allow), .chan_wr_allow(chan_wr_allow),
      .ordering_log_lock(ordering_log_lock), .channel_cfg_lock_select(channel_cfg_lock_select));
   task chk(input [7:0] g, input [7:0] e);
      n_checks = n_checks + 1;
      if (g !== e) mismatches = mismatches + 1;
      if (g !== e) $display("ERROR %0t got %h exp %h", $time, g, e);
   endtask
   task chk_lock(input [6:0] e);
      n_checks = n_checks + 1;
      if (lock_lvl !== e) mismatches = mismatches + 1;
      if (lock_lvl !== e) $display("ERROR %0t got %h exp %h", $time, lock_lvl, e);
   endtask
   task pulse(input [8:0] v, input [7:0] e);
      @(posedge mclk);
      #1 drv = v;
      @(posedge mclk);
      #1 drv = 9'h000;
      chk({1'b0, seq_wr_allow, chan_wr_allow}, e);
   endtask
   task stop_test;
      if (cyc >= 3000) mismatches = mismatches + 1;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      for (i = 0; i < 28; i = i + 1) begin
         r = rows[i];
         if (r[30]) addr_strap = r[10:8];
         // two edges let the strap synchroniser settle
         repeat (2) @(posedge mclk);
         if (r[29]) pulse(r[16:8], r[7:0]);
         else h.x(r[28], r[27:20], r[15:8], d);
         if (r[29:28] == 2'b00) chk(d, r[7:0]);
         $display("row %0d done", i);
      end
      // lock levels: monitor group with channels 5, 3, 1 picked, then ordering log too
      h.x(1, 8'hF3, 8'h2A, d);
      h.x(1, 8'hF1, 8'h02, d);
      h.x(1, 8'hF2, 8'h02, d);
      repeat (2) @(posedge mclk);
      #1 chk_lock(7'h2A);
      pulse(9'h07F, 8'h55);
      h.x(1, 8'hF1, 8'h01, d);
      h.x(1, 8'hF2, 8'h01, d);
      repeat (2) @(posedge mclk);
      #1 chk_lock(7'h6A);
      $display("lock test done");
      // clear held while a host write lands: the clear wins
      drv = 9'h100;
      h.x(1, 8'hF1, 8'h03, d);
      drv = 9'h000;
      h.x(0, 8'hF1, 8'h00, d);
      chk(d, 8'h00);
      chk_lock(7'h00);
      $display("clear test done");
      host_level_pin = 1'b0;
      repeat (2) @(posedge mclk);
      h.x(0, 8'hFA, 8'h00, d);
      chk(d, 8'h00);
      $display("level test done");
      // mid-run reset brings masks and channel mask back
      h.x(1, 8'hF1, 8'h01, d);
      h.x(1, 8'hF2, 8'h01, d);
      rst = 1'b1;
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      chk_lock(7'h00);
      h.x(0, 8'hF3, 8'h00, d);
      chk(d, 8'hC1);
      h.x(0, 8'hF1, 8'h00, d);
      chk(d, 8'h00);
      $display("reset test done");
      stop_test;
   end
endmodule // write_protect_and_bus_id_regs_tb
